// [pkg/trd_pkg.sv]
// Purpose: Shared constants and types for the transponder read-path timing block
// Assumes: 250 MHz system clock, 8 MHz crystal timebase emulated by a fractional divider
// Notes: Times are kept in their own unit and turned into cycle counts here
package trd_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SYS_CLK_MHZ = 250;
  localparam int XTAL_MHZ = 8;
  // Fractional accumulator: add XTAL per cycle, wrap at SYS gives an 8 MHz tick
  localparam logic [7:0] ACC_STEP = 8'h08;
  localparam logic [7:0] ACC_WRAP = 8'hFA;
  localparam logic [7:0] ACC_LIMIT = 8'hF2;
  // 64 crystal ticks per carrier period
  localparam int CARRIER_DIV = 64;
  localparam logic [5:0] PHASE_ZERO = 6'h00;
  localparam logic [5:0] PHASE_HALF = 6'h20;
  // Sampling steps: index k means -78.75 + 11.25*k degrees, two ticks per step
  localparam logic [3:0] STEP_RESET = 4'h8;
  localparam logic [3:0] STEP_MAX = 4'hF;
  localparam logic [5:0] STEP_TICK_OFS = 6'h32;
  localparam int SYS_CYC_PER_CARRIER = SYS_CLK_MHZ * CARRIER_DIV / XTAL_MHZ;
  // Preload timing, least times rounded up to whole cycles
  localparam int SWON_DELAY_US = 256;
  localparam int PRELOAD_LEN_US = 128;
  localparam int SETTLE_DELAY_US = 518;
  localparam int SWON_DELAY_CYC = (SWON_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRELOAD_LEN_CYC =
    (PRELOAD_LEN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_DELAY_CYC =
    (SETTLE_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_W = 18;

  typedef enum logic [3:0] {
    EV_IDLE = 4'b0001,
    EV_SETTLE = 4'b0010,
    EV_ARM = 4'b0100,
    EV_MEAS = 4'b1000
  } trd_eval_type;

  typedef enum logic [3:0] {
    PL_IDLE = 4'b0001,
    PL_SETTLE = 4'b0010,
    PL_DELAY = 4'b0100,
    PL_ACTIVE = 4'b1000
  } trd_preload_type;

  typedef struct packed {
    logic data;
    logic [3:0] step;
  } trd_sample_type;
endpackage

// [rtl/trd_top.sv]
// Purpose: Carrier generation, self-synchronous sampling phase and reference preload timing
// Assumes: All inputs synchronous to i_clk_sys; i_reset_n is the low voltage reset pin
// Notes: Demodulated bits leave through a two-entry buffer with valid/ready
//
// Contract
// - Carrier of 125 kHz is the 8 MHz crystal timebase divided by sixty-four.
// - Demodulator detects amplitude or phase modulation at data rates up to 8 kHz.
// - Sampling instant is referenced to the falling edge of drive output A.
// - Antenna phase shift of -45 to +45 degrees is compensated by sampling instant.
// - Sampling phase spans -78.75 to 90 degrees in sixteen 11.25 degree steps.
// - After reset the sampling phase is +11.25 degrees until re-evaluated.
// - Phase evaluation runs only after wake-up or reset, never otherwise.
// - Reference capacitor is preloaded after wake-up, reset and each write sequence.
// - After driver switch-on preload starts 256 us later and lasts 128 us.
// - After wake-up or reset preload starts 518 us after clock settling, 128 us long.
// - Reset low loads each flip-flop's reset value (step 8, drive B high) and switches both antenna drivers on.
`timescale 1ns/100ps
module trd_top #(
  parameter int SWON_DELAY = trd_pkg::SWON_DELAY_CYC,
  parameter int PRELOAD_LEN = trd_pkg::PRELOAD_LEN_CYC,
  parameter int SETTLE_DELAY = trd_pkg::SETTLE_DELAY_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wake_up,
  input wire logic i_osc_settled,
  input wire logic i_drivers_en,
  input wire logic i_rd_sign,
  input wire logic i_rd_cmp,
  input wire logic i_sample_ready,
  output logic o_antenna_drive_a,
  output logic o_antenna_drive_b,
  output logic o_antenna_drive_oe_n,
  output logic o_comparator_reference_cap_preload,
  output logic o_sample_valid,
  output trd_pkg::trd_sample_type o_sample,
  output logic o_overrun,
  output logic o_eval_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // Crystal timebase and carrier
  logic [7:0] acc_r;
  logic [5:0] phase_r;
  logic tick;
  assign tick = (acc_r >= trd_pkg::ACC_LIMIT);
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      acc_r <= 8'h00;
      phase_r <= 6'h00;
    end else begin
      acc_r <= tick ? 8'(acc_r + trd_pkg::ACC_STEP - trd_pkg::ACC_WRAP)
                    : 8'(acc_r + trd_pkg::ACC_STEP);
      if (tick) begin
        phase_r <= 6'(phase_r + 6'h01);
      end
    end
  end

  // Drive A is high in the upper half period; its fall marks phase zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_antenna_drive_a <= 1'b0;
      o_antenna_drive_b <= 1'b1;
      o_antenna_drive_oe_n <= 1'b0;
    end else begin
      o_antenna_drive_a <= phase_r[5];
      o_antenna_drive_b <= ~phase_r[5];
      o_antenna_drive_oe_n <= ~i_drivers_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase evaluation
  trd_pkg::trd_eval_type ev_state_r;
  logic [3:0] step_r;
  logic rd_sign_d_r;
  logic rd_rise;
  logic signed [7:0] shift;
  logic signed [7:0] step_calc;
  logic [3:0] step_best;
  assign rd_rise = i_rd_sign & ~rd_sign_d_r;
  assign shift = $signed({2'b00, phase_r}) - $signed({2'b00, trd_pkg::PHASE_HALF});
  assign step_calc = $signed({4'h0, trd_pkg::STEP_RESET}) + (shift >>> 1);
  assign step_best = (step_calc < 0) ? 4'h0 :
                     (step_calc > $signed({4'h0, trd_pkg::STEP_MAX})) ? trd_pkg::STEP_MAX :
                     step_calc[3:0];

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ev_state_r <= trd_pkg::EV_SETTLE;
      step_r <= trd_pkg::STEP_RESET;
      rd_sign_d_r <= 1'b0;
      o_eval_busy <= 1'b1;
    end else begin
      rd_sign_d_r <= i_rd_sign;
      o_eval_busy <= (ev_state_r != trd_pkg::EV_IDLE) || i_wake_up;
      case (ev_state_r)
        trd_pkg::EV_IDLE: begin
          if (i_wake_up) begin
            ev_state_r <= trd_pkg::EV_SETTLE;
          end
        end
        trd_pkg::EV_SETTLE: begin
          if (i_osc_settled) begin
            ev_state_r <= trd_pkg::EV_ARM;
          end
        end
        trd_pkg::EV_ARM: begin
          if (tick && phase_r == 6'(trd_pkg::CARRIER_DIV - 1)) begin
            ev_state_r <= trd_pkg::EV_MEAS;
          end
        end
        trd_pkg::EV_MEAS: begin
          if (rd_rise) begin
            step_r <= step_best;
            ev_state_r <= trd_pkg::EV_IDLE;
          end else if (tick && phase_r == 6'(trd_pkg::CARRIER_DIV - 1)) begin
            ev_state_r <= trd_pkg::EV_IDLE;  // No edge seen: keep previous step
          end
        end
        default: ev_state_r <= trd_pkg::EV_IDLE;
      endcase
      // A wake-up restarts an evaluation already under way, not only an idle one
      if (i_wake_up) begin
        ev_state_r <= trd_pkg::EV_SETTLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample and hold strobe, one sample per carrier period
  logic [5:0] sample_tick;
  logic sample_stb;
  assign sample_tick = 6'({step_r, 1'b0} + trd_pkg::STEP_TICK_OFS);
  assign sample_stb = tick && (phase_r == sample_tick);

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; head register feeds the port directly
  trd_pkg::trd_sample_type tail_r;
  logic tail_v_r;
  logic buf_ready;
  logic pop;
  trd_pkg::trd_sample_type new_sample;
  assign new_sample = '{data: i_rd_cmp, step: step_r};
  assign buf_ready = ~tail_v_r;
  assign pop = o_sample_valid & i_sample_ready;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_sample_valid <= 1'b0;
      o_sample <= '0;
      tail_r <= '0;
      tail_v_r <= 1'b0;
      o_overrun <= 1'b0;
    end else begin
      if (pop) begin
        o_sample_valid <= tail_v_r | (sample_stb & buf_ready);
        o_sample <= tail_v_r ? tail_r : new_sample;
        tail_v_r <= 1'b0;
        if (tail_v_r && sample_stb) begin
          tail_r <= new_sample;
          tail_v_r <= 1'b1;
        end
      end else if (sample_stb && buf_ready) begin
        if (o_sample_valid) begin
          tail_r <= new_sample;
          tail_v_r <= 1'b1;
        end else begin
          o_sample <= new_sample;
          o_sample_valid <= 1'b1;
        end
      end
      // Sampler cannot pause the carrier, so a full buffer is reported, sticky until reset
      if (sample_stb && !buf_ready && !pop) begin
        o_overrun <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference capacitor preload timer
  trd_pkg::trd_preload_type pl_state_r;
  logic [trd_pkg::TIMER_W-1:0] cnt_r;
  logic [trd_pkg::TIMER_W-1:0] lim_r;
  logic drv_en_d_r;
  logic drv_on;
  logic cnt_end;
  assign drv_on = i_drivers_en & ~drv_en_d_r;
  assign cnt_end = (cnt_r == lim_r);

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pl_state_r <= trd_pkg::PL_SETTLE;
      cnt_r <= '0;
      lim_r <= '0;
      drv_en_d_r <= 1'b1;
      o_comparator_reference_cap_preload <= 1'b0;
    end else begin
      drv_en_d_r <= i_drivers_en;
      cnt_r <= cnt_end ? '0 : cnt_r + 1'b1;
      if (i_wake_up) begin
        pl_state_r <= trd_pkg::PL_SETTLE;
        o_comparator_reference_cap_preload <= 1'b0;
      end else if (drv_on) begin
        // Write sequence ends with the drivers switching back on
        pl_state_r <= trd_pkg::PL_DELAY;
        lim_r <= trd_pkg::TIMER_W'(SWON_DELAY - 1);
        cnt_r <= '0;
        o_comparator_reference_cap_preload <= 1'b0;
      end else begin
        case (pl_state_r)
          trd_pkg::PL_IDLE: pl_state_r <= trd_pkg::PL_IDLE;
          trd_pkg::PL_SETTLE: begin
            if (i_osc_settled) begin
              pl_state_r <= trd_pkg::PL_DELAY;
              lim_r <= trd_pkg::TIMER_W'(SETTLE_DELAY - 1);
              cnt_r <= '0;
            end
          end
          trd_pkg::PL_DELAY: begin
            if (cnt_end) begin
              pl_state_r <= trd_pkg::PL_ACTIVE;
              lim_r <= trd_pkg::TIMER_W'(PRELOAD_LEN - 1);
              o_comparator_reference_cap_preload <= 1'b1;
            end
          end
          trd_pkg::PL_ACTIVE: begin
            if (cnt_end) begin
              pl_state_r <= trd_pkg::PL_IDLE;
              o_comparator_reference_cap_preload <= 1'b0;
            end
          end
          default: pl_state_r <= trd_pkg::PL_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [11:0] per_cnt_r;
  logic seen_fall_r;
  logic [trd_pkg::TIMER_W-1:0] pl_len_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      per_cnt_r <= '0;
      seen_fall_r <= 1'b0;
      pl_len_r <= '0;
    end else begin
      per_cnt_r <= $fell(o_antenna_drive_a) ? 12'h000 : 12'(per_cnt_r + 12'h001);
      seen_fall_r <= seen_fall_r | $fell(o_antenna_drive_a);
      pl_len_r <= o_comparator_reference_cap_preload ? pl_len_r + 1'b1 : '0;
    end
  end

  carrier_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ($fell(o_antenna_drive_a) && seen_fall_r) |->
      per_cnt_r == 12'(trd_pkg::SYS_CYC_PER_CARRIER - 1))
    else $error("carrier period is not 2000 cycles");
  zero_ref_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(o_antenna_drive_a) |-> $past(phase_r) == trd_pkg::PHASE_ZERO)
    else $error("drive A fell away from phase zero");
  sample_phase_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sample_stb |-> tick && 6'(phase_r - trd_pkg::STEP_TICK_OFS) == {1'b0, step_r, 1'b0})
    else $error("sample taken at wrong phase");
  centre_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (ev_state_r == trd_pkg::EV_MEAS && rd_rise && phase_r == trd_pkg::PHASE_HALF &&
     !i_wake_up) |=> step_r == trd_pkg::STEP_RESET)
    else $error("zero antenna shift did not give +11.25 step");
  reset_step_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    !i_reset_n |=> step_r == trd_pkg::STEP_RESET && !o_antenna_drive_oe_n)
    else $error("reset did not restore step or drivers");
  eval_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $changed(step_r) |-> $past(ev_state_r) == trd_pkg::EV_MEAS)
    else $error("step changed outside evaluation");
  wake_preload_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_wake_up |=> pl_state_r == trd_pkg::PL_SETTLE && ev_state_r == trd_pkg::EV_SETTLE)
    else $error("wake-up did not restart preload and evaluation");
  swon_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (drv_on && !i_wake_up) |=> lim_r == trd_pkg::TIMER_W'(SWON_DELAY - 1))
    else $error("switch-on delay not loaded");
  settle_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (pl_state_r == trd_pkg::PL_SETTLE && i_osc_settled && !i_wake_up && !drv_on) |=>
      lim_r == trd_pkg::TIMER_W'(SETTLE_DELAY - 1))
    else $error("settle delay not loaded");
  preload_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ($fell(o_comparator_reference_cap_preload) && !$past(i_wake_up) && !$past(drv_on)) |->
      pl_len_r == trd_pkg::TIMER_W'(PRELOAD_LEN))
    else $error("preload length wrong");

  eval_done_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ev_state_r == trd_pkg::EV_MEAS && rd_rise);
  preload_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(o_comparator_reference_cap_preload));
  buf_full_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    tail_v_r && o_sample_valid && !i_sample_ready);
endmodule

// [dv/trd_tag_model.sv]
// Purpose: Transponder seen through the tuned coil, as the demodulator inputs see it
// Assumes: Sign pulse placed a chosen number of cycles after drive A falls
// Notes: With drivers off the coil carries nothing, so both lines sit low
`timescale 1ns/100ps
module trd_tag_model (
  input wire logic i_clk_sys,
  input wire logic i_drive_a,
  input wire logic i_drive_oe_n,
  input wire logic [11:0] i_rise_at,
  input wire logic i_data,
  output logic o_rd_sign,
  output logic o_rd_cmp
);
  logic [11:0] cnt_r = 12'h000;
  logic a_r = 1'b0;
  logic [11:0] end_at;
  always_ff @(posedge i_clk_sys) begin
    a_r <= i_drive_a;
    cnt_r <= (a_r && !i_drive_a) ? 12'h000 : cnt_r + 12'h001;
  end
  // Short pulse so one edge never straddles the start of a measuring window
  assign end_at = i_rise_at + 12'h008;
  assign o_rd_sign = !i_drive_oe_n && cnt_r >= i_rise_at && cnt_r < end_at;
  assign o_rd_cmp = !i_drive_oe_n && i_data;
endmodule

// [dv/tag_reader_demod_timing_test.sv]
// Purpose: Self-checking bench for the read-path timing block
// Assumes: Preload delays shortened through the top parameters
// Notes: Receiver is ready by default so only the overrun test fills the buffer
`timescale 1ns/100ps
module tag_reader_demod_timing_test;
  localparam int SWON = 20;
  localparam int PLEN = 10;
  localparam int SETL = 30;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic wake = 1'b0;
  logic osc = 1'b0;
  logic drv_en = 1'b1;
  logic ready = 1'b1;
  logic tag_data = 1'b1;
  logic [11:0] rise_at = 12'hFFF;
  logic drive_a, drive_b, oe_n, preload, valid, overrun, busy, rd_sign, rd_cmp;
  trd_pkg::trd_sample_type sample;
  int n_mismatch = 0;
  int comparisons = 0;

  trd_top #(.SWON_DELAY(SWON), .PRELOAD_LEN(PLEN), .SETTLE_DELAY(SETL)) trd_top_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wake_up(wake),
    .i_osc_settled(osc), .i_drivers_en(drv_en), .i_rd_sign(rd_sign),
    .i_rd_cmp(rd_cmp), .i_sample_ready(ready), .o_antenna_drive_a(drive_a),
    .o_antenna_drive_b(drive_b), .o_antenna_drive_oe_n(oe_n),
    .o_comparator_reference_cap_preload(preload), .o_sample_valid(valid),
    .o_sample(sample), .o_overrun(overrun), .o_eval_busy(busy));
  trd_tag_model trd_tag_model_i (.i_clk_sys(i_clk_sys), .i_drive_a(drive_a),
    .i_drive_oe_n(oe_n), .i_rise_at(rise_at), .i_data(tag_data),
    .o_rd_sign(rd_sign), .o_rd_cmp(rd_cmp));

  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    n_mismatch++;
    $display("unexpected timeout on %s", what);
    close_out();
  endtask
  task automatic get_sample(output trd_pkg::trd_sample_type s);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (n > 4000) give_up("sample");
    end while (!(valid === 1'b1 && ready === 1'b1));
    s = sample;
  endtask
  task automatic time_preload(output int dly, output int wid);
    dly = 0;
    wid = 0;
    do begin
      @(posedge i_clk_sys);
      dly++;
      if (dly > 5000) give_up("preload");
    end while (preload !== 1'b1);
    while (preload === 1'b1) begin
      @(posedge i_clk_sys);
      wid++;
      if (wid > 5000) give_up("preload width");
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge i_clk_sys);
    check("eval busy", busy, 1'b1);
    while (busy !== 1'b0) begin
      @(posedge i_clk_sys);
      n++;
      if (n > 10000) give_up("evaluation");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("drive a", drive_a, 1'b0);
    check("drive b", drive_b, 1'b1);
    check("drivers on", oe_n, 1'b0);
    check("flags", {preload, valid, overrun, busy}, 4'h1);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    $display("test reset done");
  endtask
  task automatic t_carrier();
    int hi;
    int same;
    logic was;
    logic was_a;
    hi = 0;
    same = 0;
    was = drive_a;
    do begin
      was_a = was;
      @(posedge i_clk_sys);
      was = drive_a;
      hi++;
      if (hi > 4000) give_up("carrier");
    end while (!(was_a === 1'b1 && drive_a === 1'b0));
    hi = 0;
    repeat (2000) begin
      was = drive_a;
      @(posedge i_clk_sys);
      hi += int'(was);
      same += int'(drive_a === drive_b);
    end
    check("high cycles", 32'(hi), 32'h0000_03E8);
    check("fall after period", {was, drive_a}, 2'b10);
    check("b equal to a", 32'(same), 32'h0000_0000);
    $display("test carrier done");
  endtask
  task automatic t_first_sample();
    trd_pkg::trd_sample_type s;
    get_sample(s);
    check("reset step", 32'(s.step), 32'h0000_0008);
    check("data", 32'(s.data), 32'h0000_0001);
    $display("test first sample done");
  endtask
  task automatic t_preload(input bit by_drivers);
    int d;
    int w;
    if (by_drivers) begin
      drv_en <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      check("drivers off", oe_n, 1'b1);
      drv_en <= 1'b1;
    end else if (osc === 1'b1) begin
      // Clock already settled: the controller redoes the preload by a wake-up
      wake <= 1'b1;
      @(posedge i_clk_sys);
      wake <= 1'b0;
    end else begin
      osc <= 1'b1;
    end
    time_preload(d, w);
    check("preload delay", 32'(d), 32'(by_drivers ? SWON + 2 : SETL + 2));
    check("preload width", 32'(w), 32'(PLEN));
    $display("test preload done");
  endtask
  task automatic t_eval();
    int p[5] = '{40, 0, 63, 32, 20};
    int e;
    trd_pkg::trd_sample_type s;
    for (int i = 0; i < 5; i++) begin
      e = 8 + ((p[i] - 32) >>> 1);
      e = (e < 0) ? 0 : ((e > 15) ? 15 : e);
      rise_at <= 12'(31 * p[i] + 16);
      tag_data <= i[0];
      wake <= 1'b1;
      @(posedge i_clk_sys);
      wake <= 1'b0;
      wait_idle();
      get_sample(s);
      get_sample(s);
      check("step", 32'(s.step), 32'(e));
      check("data", 32'(s.data), 32'(i[0]));
    end
    // Tag moves without a wake-up: the chosen step must stay put
    rise_at <= 12'(31 * 40 + 16);
    repeat (3) get_sample(s);
    check("held step", 32'(s.step), 32'(8 + ((20 - 32) >>> 1)));
    $display("test evaluation done");
  endtask
  task automatic t_overrun();
    int pops;
    pops = 0;
    check("overrun idle", overrun, 1'b0);
    ready <= 1'b0;
    repeat (7000) @(posedge i_clk_sys);
    check("held valid", {valid, overrun}, 2'b11);
    ready <= 1'b1;
    repeat (3) begin
      @(posedge i_clk_sys);
      pops += int'(valid === 1'b1 && ready === 1'b1);
    end
    check("drained words", 32'(pops), 32'h0000_0002);
    $display("test overrun done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (19) @(posedge i_clk_sys);
    t_reset();
    t_carrier();
    t_first_sample();
    t_preload(1'b0);
    t_eval();
    t_preload(1'b1);
    t_preload(1'b0);
    t_overrun();
    close_out();
  end
endmodule
